// File: hdl/fep_top.sv
// fep_top: flash fault flag, on-board programming mode decode and boot loader sequencer.
// Assumes the serial interface measures the bit rate itself and moves whole bytes.
`timescale 1ns/10ps
module fep_top #(
   parameter int RAM_AW  = fep_pkg::RAM_AW,
   parameter int MAX_LEN = fep_pkg::MAX_LEN
) (
   input  wire logic                 MCLK,                   // System clock
   input  wire logic                 RST,                    // Synchronous reset
   input  wire logic                 WATCHDOG_RESET,         // Watchdog reset pulse
   input  wire logic                 EXTERNAL_RESET_PIN,     // Reset pin level
   input  wire logic                 HW_STANDBY_PIN,         // Hardware standby level
   input  wire logic                 FLASH_WRITE_PERMIT_PIN, // Write permit pin
   input  wire logic                 MODE_SELECT_PIN_2,      // Mode pin 2
   input  wire logic                 MODE_SELECT_PIN_1,      // Mode pin 1
   input  wire logic                 MODE_SELECT_PIN_0,      // Mode pin 0
   input  wire logic                 PE_SETUP,               // Program/erase set up
   input  wire logic                 PE_ACTIVE,              // Program/erase running
   input  wire logic                 FLASH_RD,               // Flash array read
   input  wire logic                 RAM_OVERLAY_HIT,        // Read hits RAM overlay
   input  wire logic [fep_pkg::DW-1:0] FLASH_ARR_DATA,       // Array read data
   output logic      [fep_pkg::DW-1:0] FLASH_RD_DATA,        // Data to requester
   input  wire logic                 EXC_START,              // Exception sequence begins
   input  wire fep_pkg::fep_exc_t    EXC_KIND,               // Exception kind
   input  wire logic                 SLEEP_EXEC,             // Sleep instruction run
   output logic                      PE_ALLOW,               // Program/erase permitted
   output logic                      FLASH_FAULT_FLAG,       // Fault flag
   output logic                      BOOT_MODE,              // Boot mode selected
   output logic                      USER_PROG_MODE,         // User program mode
   input  wire logic [fep_pkg::AW-1:0] REG_ADDR,             // Register address
   input  wire logic [fep_pkg::DW-1:0] REG_WDATA,            // Write data
   input  wire logic                 REG_WR,                 // Write strobe
   input  wire logic                 REG_RD,                 // Read strobe
   output logic      [fep_pkg::DW-1:0] REG_RDATA,            // Read data, next cycle
   output logic                      IRQ,                    // Interrupt level
   input  wire logic                 BAUD_LOCKED,            // Bit rate adjusted pulse
   input  wire logic                 RX_VALID,               // Received byte pulse
   input  wire logic [fep_pkg::DW-1:0] RX_DATA,              // Received byte
   output logic                      TX_VALID,               // Send byte pulse
   output logic      [fep_pkg::DW-1:0] TX_DATA,              // Byte to send
   output logic                      COPY_REQ,               // Copy erase routine
   input  wire logic                 COPY_DONE,              // Copy finished pulse
   output logic                      ERASE_ALL,              // Whole-array erase
   input  wire logic                 ERASE_DONE,             // Erase finished pulse
   input  wire logic                 ERASE_FAIL,             // Erase failed pulse
   output logic                      RAM_WE,                 // RAM write pulse
   output logic      [RAM_AW-1:0]    RAM_ADDR,               // RAM byte address
   output logic      [fep_pkg::DW-1:0] RAM_WDATA,            // RAM write data
   output logic                      BOOT_RUN                // Loaded program runs
);
   import fep_pkg::*;

   logic [5:0]      pin_s;
   logic            fault_ff;
   logic            nxt_fault;
   logic [2:0]      mode_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [IRQ_W-1:0] nxt_irq_stat;
   logic [IRQ_W-1:0] nxt_irq_mask;
   fep_boot_t       st_ff;
   fep_boot_t       nxt_st;
   logic [DW-1:0]   len_hi_ff;
   logic [LEN_W-1:0] len_ff;
   logic [LEN_W-1:0] cnt_ff;
   logic [LEN_W-1:0] nxt_len;
   logic [LEN_W-1:0] nxt_cnt;

   // Pins and the reset pin come from outside the clock domain
   fep_sync #(.W(6)) u_sync (
      .clk (MCLK),
      .rst (RST),
      .d   ({EXTERNAL_RESET_PIN, HW_STANDBY_PIN, FLASH_WRITE_PERMIT_PIN,
             MODE_SELECT_PIN_2, MODE_SELECT_PIN_1, MODE_SELECT_PIN_0}),
      .q   (pin_s)
   );

   wire pin_rst_s = pin_s[5];
   wire stby_s    = pin_s[4];
   wire fwe_s     = pin_s[3];
   wire md2_s     = pin_s[2];
   wire md1_s     = pin_s[1];
   wire md0_s     = pin_s[0];

   // Mode decode
   wire       boot_sel = fwe_s & ~md2_s & md0_s;
   wire       user_sel = fwe_s & md2_s & md0_s;
   wire       md2_eff  = md2_s ^ boot_sel;
   wire [2:0] mode_num = {md2_eff, md1_s, md0_s};
   wire       is_mode6 = (mode_num == MODE_6);
   wire       onboard  = (boot_sel | user_sel) & ~is_mode6;

   // Fault flag sources
   wire pe_busy  = PE_SETUP | PE_ACTIVE;
   wire exc_ok   = EXC_START & (EXC_KIND != EXC_RESET) & (EXC_KIND != EXC_INVALID)
                   & (EXC_KIND != EXC_TRAP) & (EXC_KIND != EXC_ZDIV);
   wire set_rd   = FLASH_RD & PE_ACTIVE & ~RAM_OVERLAY_HIT;
   wire set_exc  = exc_ok & pe_busy;
   wire set_slp  = SLEEP_EXEC & PE_ACTIVE;
   wire set_any  = set_rd | set_exc | set_slp;
   wire clr_any  = WATCHDOG_RESET | pin_rst_s | stby_s;

   // A clearing reset outranks a simultaneous error: the reset restarts the chip anyway
   assign nxt_fault = clr_any ? 1'b0 : (fault_ff | set_any);

   // Register decode
   wire sel_stat = (REG_ADDR == OFS_FAULT_STAT);
   wire sel_mode = (REG_ADDR == OFS_MODE_MON);
   wire sel_irq  = (REG_ADDR == OFS_IRQ_STAT);
   wire sel_mask = (REG_ADDR == OFS_IRQ_MASK);
   wire rd_irq   = REG_RD & sel_irq;
   wire wr_mask  = REG_WR & sel_mask;
   // No write path exists for the status address, so the flag has no software clear
   wire [DW-1:0] rd_mux = sel_stat ? {fault_ff, RSVD_ONES} :
                          sel_mode ? {{(DW-3){1'b0}}, mode_ff} :
                          sel_irq  ? {{(DW-IRQ_W){1'b0}}, irq_stat_ff} :
                          sel_mask ? {{(DW-IRQ_W){1'b0}}, irq_mask_ff} :
                          {DW{1'b0}};

   // Interrupt events; a set in the clearing read cycle survives
   wire loaded_evt = (st_ff == BT_LOAD) & (nxt_st == BT_RUN);
   wire erase_evt  = (st_ff == BT_ERASE) & ERASE_FAIL;
   wire fault_evt  = ~fault_ff & nxt_fault;
   wire [IRQ_W-1:0] irq_evt = {erase_evt, loaded_evt, fault_evt};
   assign nxt_irq_stat = (irq_stat_ff & ~{IRQ_W{rd_irq}}) | irq_evt;
   assign nxt_irq_mask = wr_mask ? REG_WDATA[IRQ_W-1:0] : irq_mask_ff;

   // Boot loader sequencer
   wire echo     = RX_VALID & ((st_ff == BT_LENH) | (st_ff == BT_LENL) | (st_ff == BT_LOAD));
   wire cnt_last = ((cnt_ff + 16'h0001) == len_ff);
   wire room     = (cnt_ff < LEN_W'(MAX_LEN));

   always_comb begin
      nxt_st  = st_ff;
      nxt_len = len_ff;
      nxt_cnt = cnt_ff;
      case (st_ff)
         BT_IDLE: begin
            if (boot_sel) begin
               nxt_st = BT_BAUD;
            end
         end
         BT_BAUD: begin
            if (BAUD_LOCKED) begin
               nxt_st = BT_ACK0;
            end
         end
         BT_ACK0: begin
            nxt_st = BT_WAIT55;
         end
         BT_WAIT55: begin
            if (RX_VALID && RX_DATA == BYTE_CHECK) begin
               nxt_st = BT_COPY;
            end
         end
         BT_COPY: begin
            if (COPY_DONE) begin
               nxt_st = BT_ERASE;
            end
         end
         BT_ERASE: begin
            if (ERASE_FAIL) begin
               nxt_st = BT_FAIL;
            end else if (ERASE_DONE) begin
               nxt_st = BT_SENDAA;
            end
         end
         BT_SENDAA: begin
            nxt_st = BT_LENH;
         end
         BT_LENH: begin
            if (RX_VALID) begin
               nxt_st = BT_LENL;
            end
         end
         BT_LENL: begin
            if (RX_VALID) begin
               nxt_len = {len_hi_ff, RX_DATA};
               nxt_cnt = '0;
               nxt_st  = ({len_hi_ff, RX_DATA} == '0) ? BT_RUN : BT_LOAD;
            end
         end
         BT_LOAD: begin
            if (RX_VALID) begin
               nxt_cnt = cnt_ff + 16'h0001;
               if (cnt_last) begin
                  nxt_st = BT_RUN;
               end
            end
         end
         default: begin
            nxt_st = st_ff;
         end
      endcase
   end

   // Outgoing serial bytes: echo has priority, the state bytes never meet an echo
   wire fail_in = (nxt_st == BT_FAIL) & (st_ff != BT_FAIL);
   wire tx_go   = echo | (st_ff == BT_ACK0) | (st_ff == BT_SENDAA) | fail_in;
   wire [DW-1:0] tx_byte = echo                 ? RX_DATA :
                           (st_ff == BT_ACK0)   ? BYTE_ACK :
                           (st_ff == BT_SENDAA) ? BYTE_GO : BYTE_ERR;
   // Bytes beyond the RAM space are echoed but not stored
   wire ram_go  = (st_ff == BT_LOAD) & RX_VALID & room;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         fault_ff    <= 1'b0;
         mode_ff     <= '0;
         irq_stat_ff <= '0;
         irq_mask_ff <= '0;
         st_ff       <= BT_IDLE;
         len_hi_ff   <= '0;
         len_ff      <= '0;
         cnt_ff      <= '0;
      end else begin
         fault_ff    <= nxt_fault;
         mode_ff     <= mode_num;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         st_ff       <= nxt_st;
         len_hi_ff   <= (st_ff == BT_LENH && RX_VALID) ? RX_DATA : len_hi_ff;
         len_ff      <= nxt_len;
         cnt_ff      <= nxt_cnt;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         FLASH_RD_DATA    <= '0;
         PE_ALLOW         <= 1'b0;
         FLASH_FAULT_FLAG <= 1'b0;
         BOOT_MODE        <= 1'b0;
         USER_PROG_MODE   <= 1'b0;
         REG_RDATA        <= '0;
         IRQ              <= 1'b0;
      end else begin
         FLASH_RD_DATA    <= PE_ACTIVE ? UNDEF_DATA : FLASH_ARR_DATA;
         PE_ALLOW         <= onboard & ~nxt_fault;
         FLASH_FAULT_FLAG <= nxt_fault;
         BOOT_MODE        <= boot_sel & ~is_mode6;
         USER_PROG_MODE   <= user_sel & ~is_mode6;
         REG_RDATA        <= REG_RD ? rd_mux : '0;
         IRQ              <= |(nxt_irq_stat & nxt_irq_mask);
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         TX_VALID  <= 1'b0;
         TX_DATA   <= '0;
         COPY_REQ  <= 1'b0;
         ERASE_ALL <= 1'b0;
         RAM_WE    <= 1'b0;
         RAM_ADDR  <= '0;
         RAM_WDATA <= '0;
         BOOT_RUN  <= 1'b0;
      end else begin
         TX_VALID  <= tx_go;
         TX_DATA   <= tx_go ? tx_byte : TX_DATA;
         COPY_REQ  <= (nxt_st == BT_COPY);
         ERASE_ALL <= (nxt_st == BT_ERASE) & ~nxt_fault;
         RAM_WE    <= ram_go;
         RAM_ADDR  <= ram_go ? cnt_ff[RAM_AW-1:0] : RAM_ADDR;
         RAM_WDATA <= ram_go ? RX_DATA : RAM_WDATA;
         BOOT_RUN  <= (nxt_st == BT_RUN);
      end
   end

   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   property p_rd_sets;
      set_rd && !clr_any |=> fault_ff && FLASH_FAULT_FLAG;
   endproperty
   a_rd_sets: assert property (p_rd_sets) else $error("flash read in P/E did not set flag");

   property p_undef;
      FLASH_RD && PE_ACTIVE |=> FLASH_RD_DATA == UNDEF_DATA;
   endproperty
   a_undef: assert property (p_undef) else $error("read during P/E returned array data");

   property p_exc_sets;
      EXC_START && EXC_KIND == EXC_IRQ && PE_SETUP && !clr_any |=> fault_ff;
   endproperty
   a_exc_sets: assert property (p_exc_sets) else $error("exception did not set flag");

   property p_exc_excl;
      !fault_ff && !clr_any && EXC_START && EXC_KIND == EXC_TRAP && !set_rd && !set_slp
         |=> !fault_ff;
   endproperty
   a_exc_excl: assert property (p_exc_excl) else $error("excluded exception set flag");

   property p_slp_sets;
      SLEEP_EXEC && PE_ACTIVE && !clr_any |=> fault_ff;
   endproperty
   a_slp_sets: assert property (p_slp_sets) else $error("sleep in P/E did not set flag");

   property p_block;
      FLASH_FAULT_FLAG |-> !PE_ALLOW && !ERASE_ALL;
   endproperty
   a_block: assert property (p_block) else $error("program/erase allowed with flag set");

   property p_clear;
      clr_any |=> !fault_ff ##1 (fault_ff == $past(set_any) || $past(clr_any));
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared by reset source");

   property p_hold;
      fault_ff && !clr_any |=> fault_ff;
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped without reset source");

   property p_rsvd;
      REG_RD && sel_stat |=> REG_RDATA[6:0] == RSVD_ONES && REG_RDATA[7] == $past(fault_ff);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("status read value wrong");

   property p_permit;
      onboard && !fault_ff && !set_any && !clr_any |=> PE_ALLOW;
   endproperty
   a_permit: assert property (p_permit) else $error("on-board mode did not permit P/E");

   property p_mode6;
      is_mode6 |=> !PE_ALLOW && !BOOT_MODE && !USER_PROG_MODE;
   endproperty
   a_mode6: assert property (p_mode6) else $error("mode 6 offered programming");

   property p_mode_mon;
      REG_RD && sel_mode |=> REG_RDATA[2:0] == $past(mode_ff);
   endproperty
   a_mode_mon: assert property (p_mode_mon) else $error("mode monitor read wrong");

   property p_copy;
      $rose(COPY_REQ) |-> $past(RX_VALID) && $past(RX_DATA) == BYTE_CHECK;
   endproperty
   a_copy: assert property (p_copy) else $error("copy started without link check");

   property p_echo;
      echo |=> TX_VALID && TX_DATA == $past(RX_DATA);
   endproperty
   a_echo: assert property (p_echo) else $error("received byte not echoed");

   c_fault: cover property (!fault_ff ##1 fault_ff);
   c_run: cover property ($rose(BOOT_RUN));
   c_erase_fail: cover property (st_ff == BT_ERASE && ERASE_FAIL);
   c_undef: cover property (FLASH_RD && PE_ACTIVE);
endmodule : fep_top

// File: hdl/fep_pkg.sv
// fep_pkg: constants, register map and types for the flash fault protect and boot entry block.
// Assumes an 8-bit register port and a byte-wide serial interface beside the block.
// Function
// - Flash array read during program/erase sets fault flag; RAM overlay reads excluded.
// - Flash read during program/erase returns undefined data.
// - Qualifying exception sequence just before program/erase sets fault flag.
// - Sleep or software standby during program/erase sets fault flag.
// - Fault flag set blocks all program and erase; clear means no protection.
// - Fault flag starts at zero; cleared by watchdog reset, pin reset, hardware standby.
// - Low seven status bits ignore writes and read as one.
// - Selected on-board programming mode permits program, erase and verify.
// - In boot mode mode pin 2 is read inverted.
// - Mode 6 offers neither boot mode nor user program mode.
// - Mode monitor register reports mode 5 or 7 as in normal operation.
// - Boot loader starts, checks serial link, then copies erase routine into RAM.
// - Boot mode erases the whole array to all ones before new content.
// - Host sends zero bytes; device answers one zero byte; host replies 55.
// - After AA, host sends two-byte length high first, then program; all echoed.
package fep_pkg;
   localparam int DW = 8;
   localparam int AW = 4;
   localparam int RAM_AW = 12;
   localparam int MAX_LEN = 3072;
   localparam int LEN_W = 16;

   localparam logic [AW-1:0] OFS_FAULT_STAT = 4'h0;
   localparam logic [AW-1:0] OFS_MODE_MON = 4'h1;
   localparam logic [AW-1:0] OFS_IRQ_STAT = 4'h2;
   localparam logic [AW-1:0] OFS_IRQ_MASK = 4'h3;

   localparam logic [6:0] RSVD_ONES = 7'h7F;
   localparam logic [DW-1:0] UNDEF_DATA = 8'hA5;

   localparam logic [2:0] MODE_5 = 3'h5;
   localparam logic [2:0] MODE_6 = 3'h6;
   localparam logic [2:0] MODE_7 = 3'h7;

   localparam logic [DW-1:0] BYTE_ACK = 8'h00;
   localparam logic [DW-1:0] BYTE_CHECK = 8'h55;
   localparam logic [DW-1:0] BYTE_GO = 8'hAA;
   localparam logic [DW-1:0] BYTE_ERR = 8'hFF;

   localparam int IRQ_W = 3;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_LOADED = 1;
   localparam int IRQ_ERASE_ERR = 2;

   typedef enum logic [2:0] {
      EXC_RESET, EXC_INVALID, EXC_TRAP, EXC_ZDIV, EXC_IRQ, EXC_NMI
   } fep_exc_t;

   typedef enum logic [3:0] {
      BT_IDLE, BT_BAUD, BT_ACK0, BT_WAIT55, BT_COPY, BT_ERASE,
      BT_SENDAA, BT_LENH, BT_LENL, BT_LOAD, BT_RUN, BT_FAIL
   } fep_boot_t;
endpackage : fep_pkg

// File: hdl/fep_sync.sv
// fep_sync: two-stage synchroniser for a group of slow pin levels.
// Assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/10ps
module fep_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,   // System clock
   input  wire logic         rst,   // Synchronous reset
   input  wire logic [W-1:0] d,     // Asynchronous levels
   output logic      [W-1:0] q      // Synchronised levels
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule : fep_sync

// File: dv/fep_host_model.sv
// fep_host_model: host on the boot link, seen through the serial unit's byte ports.
// Assumes the serial unit reports bit-rate lock as a pulse and moves whole bytes.
`timescale 1ns/10ps
module fep_host_model #(
   parameter int LEN = 5
) (
   input  wire logic       clk,         // System clock
   input  wire logic       go,          // Start of the boot dialogue
   input  wire logic       tx_valid,    // Byte from the device
   input  wire logic [7:0] tx_data,     // Its value
   output logic            baud_locked, // Rate adjusted pulse
   output logic            rx_valid,    // Byte to the device
   output logic      [7:0] rx_data      // Its value
);
   int seed = 23;
   task automatic send(input logic [7:0] b);
      // Random gaps exercise both a prompt and a slow host
      repeat (1 + ($random(seed) & 7)) @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= b;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data  <= ~b;
   endtask : send
   task automatic wait_tx(input logic [7:0] b);
      @(posedge clk);
      // An erase error byte also ends the wait; the dialogue stops there
      while (!(tx_valid === 1'b1 && (tx_data === b || tx_data === 8'hFF))) @(posedge clk);
   endtask : wait_tx
   initial begin
      baud_locked = 1'b0;
      rx_valid    = 1'b0;
      rx_data     = 8'h00;
      // One dialogue per rise of go, so the bench can restart the device
      forever begin
         wait (go);
         // Device needs time after reset before it can measure the rate
         repeat (100) @(posedge clk);
         baud_locked <= 1'b1;
         @(posedge clk);
         baud_locked <= 1'b0;
         wait_tx(8'h00);
         send(8'h55);
         wait_tx(8'hAA);
         if (tx_data === 8'hAA) begin
            send(LEN[15:8]);
            send(LEN[7:0]);
            repeat (LEN) send(8'($random(seed)));
         end
         wait (!go);
      end
   end
endmodule : fep_host_model

// File: dv/testbench.sv
// testbench: self-checking bench for fep_top with a host model on the boot link.
// Assumes fep_pkg is compiled first; copy and erase engines are answered here.
`timescale 1ns/10ps
module testbench;
   import fep_pkg::*;
   logic MCLK, RST, WATCHDOG_RESET, EXTERNAL_RESET_PIN, HW_STANDBY_PIN, PE_SETUP;
   logic FLASH_WRITE_PERMIT_PIN, MODE_SELECT_PIN_2, MODE_SELECT_PIN_1, MODE_SELECT_PIN_0;
   logic PE_ACTIVE, FLASH_RD, RAM_OVERLAY_HIT, EXC_START, SLEEP_EXEC, REG_WR, REG_RD;
   logic IRQ, BAUD_LOCKED, RX_VALID, TX_VALID, COPY_REQ, ERASE_ALL, RAM_WE;
   logic BOOT_RUN, PE_ALLOW, FLASH_FAULT_FLAG, BOOT_MODE, USER_PROG_MODE;
   logic COPY_DONE = 1'b0, ERASE_DONE = 1'b0, host_go = 1'b0, cp = 1'b0, er = 1'b0;
   logic ERASE_FAIL = 1'b0, fail_run = 1'b0;
   logic [DW-1:0]     FLASH_ARR_DATA, FLASH_RD_DATA, REG_WDATA, REG_RDATA;
   logic [DW-1:0]     RX_DATA, TX_DATA, RAM_WDATA;
   logic [AW-1:0]     REG_ADDR;
   logic [RAM_AW-1:0] RAM_ADDR;
   fep_exc_t          EXC_KIND;
   logic [DW-1:0]     txq[$], rxq[$];
   int num_errors = 0, checks = 0, seed = 23, ram_n = 0;
   localparam int LEN = 5;

   fep_top i_dut (.*);
   fep_host_model #(.LEN(LEN)) i_host (.clk(MCLK), .go(host_go), .tx_valid(TX_VALID),
      .tx_data(TX_DATA), .baud_locked(BAUD_LOCKED), .rx_valid(RX_VALID), .rx_data(RX_DATA));

   function automatic logic is_boot(input logic [3:0] p);
      return p[3] & ~p[2] & p[0];
   endfunction : is_boot
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chk_bit
   task automatic end_sim;
      if (num_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge MCLK);
      {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
      @(posedge MCLK);
      REG_WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge MCLK);
      {REG_RD, REG_ADDR} <= {1'b1, a};
      @(posedge MCLK);
      REG_RD <= 1'b0;
      #1 chk(REG_RDATA, e);
   endtask : rd
   // One-cycle event with program/erase state; pins stay in user program mode
   task automatic ev(input logic fr, ovl, exc, slp, set, act, input fep_exc_t k,
                     input logic e);
      logic [DW-1:0] d;
      d = 8'($random(seed));
      @(posedge MCLK);
      {FLASH_RD, RAM_OVERLAY_HIT, EXC_START, SLEEP_EXEC, PE_SETUP, PE_ACTIVE} <=
         {fr, ovl, exc, slp, set, act};
      {EXC_KIND, FLASH_ARR_DATA} <= {k, d};
      @(posedge MCLK);
      {FLASH_RD, EXC_START, SLEEP_EXEC, PE_SETUP, PE_ACTIVE} <= 5'h00;
      #1 chk(FLASH_RD_DATA, act ? UNDEF_DATA : d);
      chk_bit(FLASH_FAULT_FLAG, e);
      chk_bit(PE_ALLOW, ~e);
   endtask : ev
   task automatic clr(input int s);
      @(posedge MCLK);
      {WATCHDOG_RESET, EXTERNAL_RESET_PIN, HW_STANDBY_PIN} <= 3'(3'h4 >> s);
      @(posedge MCLK);
      {WATCHDOG_RESET, EXTERNAL_RESET_PIN, HW_STANDBY_PIN} <= 3'h0;
      repeat (4) @(posedge MCLK);
      #1 chk_bit(FLASH_FAULT_FLAG, 1'b0);
   endtask : clr
   // Boot dialogue from a fresh reset; f makes the whole-array erase fail
   task automatic boot(input logic [3:0] p, input logic f);
      @(posedge MCLK);
      RST <= 1'b1;
      host_go <= 1'b0;
      fail_run <= f;
      {FLASH_WRITE_PERMIT_PIN, MODE_SELECT_PIN_2, MODE_SELECT_PIN_1, MODE_SELECT_PIN_0} <= p;
      txq.delete();
      rxq.delete();
      ram_n = 0;
      repeat (6) @(posedge MCLK);
      RST <= 1'b0;
      host_go <= 1'b1;
      for (int i = 0; i < 4000 && BOOT_RUN !== 1'b1 && !(f && txq.size() > 1); i++)
         @(posedge MCLK);
      repeat (4) @(posedge MCLK);
   endtask : boot

   initial begin
      MCLK = 1'b0;
      forever #25 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      COPY_DONE  <= COPY_REQ & ~COPY_DONE;
      ERASE_DONE <= ERASE_ALL & ~ERASE_DONE & ~fail_run;
      ERASE_FAIL <= ERASE_ALL & ~ERASE_FAIL & fail_run;
      if (RST) {cp, er} = 2'b00;
      if (COPY_REQ) cp = 1'b1;
      if (ERASE_ALL) er = cp;
      if (RX_VALID) rxq.push_back(RX_DATA);
      if (TX_VALID) txq.push_back(TX_DATA);
      if (TX_VALID && TX_DATA === BYTE_GO) chk_bit(er, 1'b1);
      if (RAM_WE) begin
         chk(8'(RAM_ADDR), 8'(ram_n));
         chk(RAM_WDATA, rxq[rxq.size()-1]);
         ram_n++;
      end
   end
   // Whole run is a few hundred cycles; twenty thousand means a hang
   initial begin
      #1000000;
      num_errors++;
      end_sim();
   end
   initial begin
      RST = 1'b1;
      {WATCHDOG_RESET, EXTERNAL_RESET_PIN, HW_STANDBY_PIN, PE_SETUP, PE_ACTIVE, FLASH_RD,
       RAM_OVERLAY_HIT, EXC_START, SLEEP_EXEC, REG_WR, REG_RD} = '0;
      {FLASH_WRITE_PERMIT_PIN, MODE_SELECT_PIN_2, MODE_SELECT_PIN_1, MODE_SELECT_PIN_0} =
         4'hD;
      {FLASH_ARR_DATA, REG_WDATA, REG_ADDR} = '0;
      EXC_KIND = EXC_RESET;
      repeat (6) @(posedge MCLK);
      RST <= 1'b0;
      repeat (4) @(posedge MCLK);
      rd(OFS_FAULT_STAT, {1'b0, RSVD_ONES});
      rd(OFS_IRQ_MASK, 8'h00);
      rd(4'hF, 8'h00);
      wr(OFS_IRQ_MASK, 8'h07);
      ev(1, 0, 0, 0, 0, 0, EXC_RESET, 0);
      ev(1, 1, 0, 0, 0, 1, EXC_RESET, 0);
      ev(1, 0, 0, 0, 0, 1, EXC_RESET, 1);
      chk_bit(IRQ, 1'b1);
      wr(OFS_FAULT_STAT, 8'h00);
      rd(OFS_FAULT_STAT, 8'hFF);
      rd(OFS_IRQ_STAT, 8'h01);
      chk_bit(IRQ, 1'b0);
      clr(0);
      for (int k = 0; k < 6; k++) begin
         ev(0, 0, 1, 0, 1, 0, fep_exc_t'(k), fep_exc_t'(k) inside {EXC_IRQ, EXC_NMI});
         clr(k % 3);
      end
      ev(0, 0, 1, 0, 0, 0, EXC_NMI, 0);
      ev(0, 0, 0, 1, 1, 0, EXC_RESET, 0);
      ev(0, 0, 0, 1, 0, 1, EXC_RESET, 1);
      clr(2);
      for (int m = 0; m < 16; m++) begin
         @(posedge MCLK);
         {FLASH_WRITE_PERMIT_PIN, MODE_SELECT_PIN_2, MODE_SELECT_PIN_1, MODE_SELECT_PIN_0} <=
            4'(m);
         repeat (4) @(posedge MCLK);
         #1 chk_bit(BOOT_MODE, is_boot(4'(m)));
         chk_bit(USER_PROG_MODE, m[3] & m[2] & m[0]);
         chk_bit(PE_ALLOW, m[3] & m[0]);
         rd(OFS_MODE_MON, {5'h00, m[2] ^ is_boot(4'(m)), 2'(m)});
      end
      boot(4'h9, 1'b1);
      #1 chk(8'(txq.size()), 8'h02);
      chk(txq[0], BYTE_ACK);
      chk(txq[1], BYTE_ERR);
      chk_bit(BOOT_RUN, 1'b0);
      rd(OFS_IRQ_STAT, 8'h04);
      rd(OFS_MODE_MON, 8'h05);
      boot(4'hB, 1'b0);
      #1 chk_bit(BOOT_RUN, 1'b1);
      chk(8'(txq.size()), 8'(rxq.size() + 1));
      chk(txq[0], BYTE_ACK);
      foreach (rxq[i]) chk(txq[i+1], i == 0 ? BYTE_GO : rxq[i]);
      chk(8'(ram_n), 8'(LEN));
      rd(OFS_IRQ_STAT, 8'h02);
      rd(OFS_MODE_MON, 8'h07);
      end_sim();
   end
endmodule : testbench
